// file: include/lfso_cfg.svh
// Constants for the serial-lane frame sync output block.
// Assumes inclusion by bare name from the frame sync output core file.
`ifndef LFSO_CFG_SVH
`define LFSO_CFG_SVH
`define LFSO_LANE_RATE_10B_MBPS 620
`define LFSO_LANE_RATE_8B_MBPS  496
`define LFSO_ADDR_TRAIN    8'h82
`define LFSO_ADDR_MARKER   8'h83
`define LFSO_ADDR_CLS_BLK  8'h84
`define LFSO_ADDR_CLS_IMG  8'h85
`define LFSO_ADDR_CLS_CRC  8'h86
`define LFSO_ADDR_CLS_TRN  8'h87
`define LFSO_ADDR_MODE     8'h90
`define LFSO_ADDR_BLACK    8'h91
`define LFSO_ADDR_WORDS    8'h92
`define LFSO_ADDR_Y0_FIRST 8'h93
`define LFSO_ADDR_Y0_LAST  8'h94
`define LFSO_ADDR_Y1_FIRST 8'h95
`define LFSO_ADDR_Y1_LAST  8'h96
`define LFSO_ADDR_OVH      8'h97
`define LFSO_ADDR_STATUS   8'h98
`define LFSO_RST_TRAIN     10'h3_A6
`define LFSO_RST_MARKER    7'h2A
`define LFSO_RST_CLS_BLK   10'h0_15
`define LFSO_RST_CLS_IMG   10'h0_35
`define LFSO_RST_CLS_CRC   10'h0_59
`define LFSO_RST_CLS_TRN   10'h3_A6
`define LFSO_RST_BLACK     8'h08
`define LFSO_RST_WORDS     10'h0_A0
`define LFSO_RST_Y0_FIRST  11'h0_00
`define LFSO_RST_Y0_LAST   11'h0_FF
`define LFSO_RST_Y1_FIRST  11'h0_80
`define LFSO_RST_Y1_LAST   11'h1_7F
`define LFSO_RST_OVH       12'h0_40
`define LFSO_TYPE_FS       3'h5
`define LFSO_TYPE_FE       3'h6
`define LFSO_TYPE_LS       3'h1
`define LFSO_TYPE_LE       3'h2
`define LFSO_FIFO_DEPTH    16
`define LFSO_PIX_WIDTH     40
`endif

// file: include/lfso_pkg.sv
// Types for the frame sync output block.
// Assumes lfso_cfg.svh holds the numeric constants.
package lfso_pkg;
  typedef enum logic [7:0] {
    ST_IDLE       = 8'b0000_0001,
    ST_OVERHEAD   = 8'b0000_0010,
    ST_BLACK      = 8'b0000_0100,
    ST_CODE_BEGIN = 8'b0000_1000,
    ST_ID_BEGIN   = 8'b0001_0000,
    ST_PIXELS     = 8'b0010_0000,
    ST_CODE_END   = 8'b0100_0000,
    ST_ID_END     = 8'b1000_0000
  } lfso_state_t;
endpackage : lfso_pkg

// file: core/lfso_fifo.sv
// Pixel word FIFO with registered read data.
// Assumes one clock; both sides in the same domain.
`timescale 1ns/100ps
`default_nettype none
module lfso_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  // Drain side
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             load;

  assign push = in_valid_in && in_ready_out;
  // Output register refills whenever it is empty or being drained
  assign load = (count_reg != '0) && (!out_valid_out || out_ready_in);
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(load);

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr_reg   <= '0;
      rd_ptr_reg   <= '0;
      count_reg    <= '0;
      in_ready_out <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (load) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg    <= count_next;
      in_ready_out <= (count_next != (AW+1)'(DEPTH));
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      out_data_out  <= '0;
      out_valid_out <= 1'b0;
    end else if (load) begin
      out_data_out  <= mem[rd_ptr_reg];
      out_valid_out <= 1'b1;
    end else if (out_ready_in) begin
      out_valid_out <= 1'b0;
    end
  end
endmodule : lfso_fifo
`default_nettype wire

// file: core/lfso_frame_sync_output.sv
// Frame sync output: four data lanes plus sync lane, one word per slot.
// Assumes register port and frame trigger come from logic on sys_clk_in.
`timescale 1ns/100ps
`default_nettype none
`include "lfso_cfg.svh"
module lfso_frame_sync_output (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  // Word clock from the link, sampled
  input  wire logic        word_clk_in,
  // Frame trigger from the sequencer
  input  wire logic        frame_trig_in,
  // Pixel words from the readout chain, lane 3 in the top bits
  input  wire logic [39:0] pix_data_in,
  input  wire logic        pix_valid_in,
  output logic             pix_ready_out,
  // Register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [15:0]      reg_rdata_out,
  // Lane words
  output logic [9:0]       lane0_out,
  output logic [9:0]       lane1_out,
  output logic [9:0]       lane2_out,
  output logic [9:0]       lane3_out,
  output logic [9:0]       sync_word_out,
  output logic             frame_busy_out
);
  logic [9:0]  train_reg;
  logic [6:0]  marker_reg;
  logic [9:0]  cls_blk_reg;
  logic [9:0]  cls_img_reg;
  logic [9:0]  cls_crc_reg;
  logic [9:0]  cls_trn_reg;
  logic        mode8_reg;
  logic [7:0]  black_reg;
  logic [9:0]  words_reg;
  logic [10:0] y0_first_reg;
  logic [10:0] y0_last_reg;
  logic [10:0] y1_first_reg;
  logic [10:0] y1_last_reg;
  logic [11:0] ovh_reg;
  lfso_pkg::lfso_state_t state_reg;
  lfso_pkg::lfso_state_t state_next;
  logic        wclk_meta_reg;
  logic        wclk_sync_reg;
  logic        wclk_prev_reg;
  logic        slot;
  logic        pend_reg;
  logic [11:0] ovh_cnt_reg;
  logic [7:0]  line_cnt_reg;
  logic [9:0]  word_cnt_reg;
  logic [10:0] row_reg;
  logic [10:0] row_first;
  logic [10:0] row_stop;
  logic        win0_act;
  logic        win1_act;
  logic        any_act;
  logic [2:0]  hid;
  logic        first_row;
  logic        last_row;
  logic        ovh_done;
  logic        last_word;
  logic [39:0] fifo_data;
  logic        fifo_valid;
  logic        fifo_pop;
  logic [9:0]  sync_pre;
  logic        data_sel;

  lfso_fifo #(
    .WIDTH (`LFSO_PIX_WIDTH),
    .DEPTH (`LFSO_FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (sys_clk_in),
    .rstn_in       (rstn_in),
    .in_data_in    (pix_data_in),
    .in_valid_in   (pix_valid_in),
    .in_ready_out  (pix_ready_out),
    .out_data_out  (fifo_data),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_pop)
  );

  // reduced words keep bits 9:2 in the low byte
  function automatic logic [9:0] fmt(input logic [9:0] w, input logic m8);
    fmt = m8 ? {2'b00, w[9:2]} : w;
  endfunction : fmt

  // Register port
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      train_reg    <= `LFSO_RST_TRAIN;
      marker_reg   <= `LFSO_RST_MARKER;
      cls_blk_reg  <= `LFSO_RST_CLS_BLK;
      cls_img_reg  <= `LFSO_RST_CLS_IMG;
      cls_crc_reg  <= `LFSO_RST_CLS_CRC;
      cls_trn_reg  <= `LFSO_RST_CLS_TRN;
      mode8_reg    <= 1'b0;
      black_reg    <= `LFSO_RST_BLACK;
      words_reg    <= `LFSO_RST_WORDS;
      y0_first_reg <= `LFSO_RST_Y0_FIRST;
      y0_last_reg  <= `LFSO_RST_Y0_LAST;
      y1_first_reg <= `LFSO_RST_Y1_FIRST;
      y1_last_reg  <= `LFSO_RST_Y1_LAST;
      ovh_reg      <= `LFSO_RST_OVH;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `LFSO_ADDR_TRAIN) begin
        train_reg <= reg_wdata_in[9:0];
      end else if (reg_addr_in == `LFSO_ADDR_MARKER) begin
        marker_reg <= reg_wdata_in[6:0];
      end else if (reg_addr_in == `LFSO_ADDR_CLS_BLK) begin
        cls_blk_reg <= reg_wdata_in[9:0];
      end else if (reg_addr_in == `LFSO_ADDR_CLS_IMG) begin
        cls_img_reg <= reg_wdata_in[9:0];
      end else if (reg_addr_in == `LFSO_ADDR_CLS_CRC) begin
        cls_crc_reg <= reg_wdata_in[9:0];
      end else if (reg_addr_in == `LFSO_ADDR_CLS_TRN) begin
        cls_trn_reg <= reg_wdata_in[9:0];
      end else if (reg_addr_in == `LFSO_ADDR_MODE) begin
        mode8_reg <= reg_wdata_in[0];
      end else if (reg_addr_in == `LFSO_ADDR_BLACK) begin
        black_reg <= reg_wdata_in[7:0];
      end else if (reg_addr_in == `LFSO_ADDR_WORDS) begin
        words_reg <= reg_wdata_in[9:0];
      end else if (reg_addr_in == `LFSO_ADDR_Y0_FIRST) begin
        y0_first_reg <= reg_wdata_in[10:0];
      end else if (reg_addr_in == `LFSO_ADDR_Y0_LAST) begin
        y0_last_reg <= reg_wdata_in[10:0];
      end else if (reg_addr_in == `LFSO_ADDR_Y1_FIRST) begin
        y1_first_reg <= reg_wdata_in[10:0];
      end else if (reg_addr_in == `LFSO_ADDR_Y1_LAST) begin
        y1_last_reg <= reg_wdata_in[10:0];
      end else if (reg_addr_in == `LFSO_ADDR_OVH) begin
        ovh_reg <= reg_wdata_in[11:0];
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      if (reg_addr_in == `LFSO_ADDR_TRAIN) begin
        reg_rdata_out <= {6'h00, train_reg};
      end else if (reg_addr_in == `LFSO_ADDR_MARKER) begin
        reg_rdata_out <= {9'h000, marker_reg};
      end else if (reg_addr_in == `LFSO_ADDR_CLS_BLK) begin
        reg_rdata_out <= {6'h00, cls_blk_reg};
      end else if (reg_addr_in == `LFSO_ADDR_CLS_IMG) begin
        reg_rdata_out <= {6'h00, cls_img_reg};
      end else if (reg_addr_in == `LFSO_ADDR_CLS_CRC) begin
        reg_rdata_out <= {6'h00, cls_crc_reg};
      end else if (reg_addr_in == `LFSO_ADDR_CLS_TRN) begin
        reg_rdata_out <= {6'h00, cls_trn_reg};
      end else if (reg_addr_in == `LFSO_ADDR_MODE) begin
        reg_rdata_out <= {15'h0000, mode8_reg};
      end else if (reg_addr_in == `LFSO_ADDR_BLACK) begin
        reg_rdata_out <= {8'h00, black_reg};
      end else if (reg_addr_in == `LFSO_ADDR_WORDS) begin
        reg_rdata_out <= {6'h00, words_reg};
      end else if (reg_addr_in == `LFSO_ADDR_Y0_FIRST) begin
        reg_rdata_out <= {5'h00, y0_first_reg};
      end else if (reg_addr_in == `LFSO_ADDR_Y0_LAST) begin
        reg_rdata_out <= {5'h00, y0_last_reg};
      end else if (reg_addr_in == `LFSO_ADDR_Y1_FIRST) begin
        reg_rdata_out <= {5'h00, y1_first_reg};
      end else if (reg_addr_in == `LFSO_ADDR_Y1_LAST) begin
        reg_rdata_out <= {5'h00, y1_last_reg};
      end else if (reg_addr_in == `LFSO_ADDR_OVH) begin
        reg_rdata_out <= {4'h0, ovh_reg};
      end else if (reg_addr_in == `LFSO_ADDR_STATUS) begin
        reg_rdata_out <= {row_reg[7:0], state_reg};
      end else begin
        reg_rdata_out <= 16'h0000;
      end
    end
  end

  // Word clock synchroniser; slot marks each rising edge
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wclk_meta_reg <= 1'b0;
      wclk_sync_reg <= 1'b0;
      wclk_prev_reg <= 1'b0;
    end else begin
      wclk_meta_reg <= word_clk_in;
      wclk_sync_reg <= wclk_meta_reg;
      wclk_prev_reg <= wclk_sync_reg;
    end
  end
  assign slot = wclk_sync_reg && !wclk_prev_reg;

  // window membership of the current row
  assign win0_act  = (row_reg >= y0_first_reg) && (row_reg <= y0_last_reg);
  assign win1_act  = (row_reg >= y1_first_reg) && (row_reg <= y1_last_reg);
  assign any_act   = win0_act || win1_act;
  // highest active window owns the codes
  assign hid       = win1_act ? 3'h1 : 3'h0;
  assign first_row = win1_act ? (row_reg == y1_first_reg) : (row_reg == y0_first_reg);
  assign last_row  = win1_act ? (row_reg == y1_last_reg) : (row_reg == y0_last_reg);
  assign row_first = (y0_first_reg < y1_first_reg) ? y0_first_reg : y1_first_reg;
  assign row_stop  = (y0_last_reg > y1_last_reg) ? y0_last_reg : y1_last_reg;
  assign ovh_done  = (ovh_cnt_reg == ovh_reg - 12'h001);
  assign last_word = (word_cnt_reg == words_reg - 10'h001);
  // Missing pixel word stalls the line rather than breaking slot pairing
  assign data_sel  = ((state_reg == lfso_pkg::ST_BLACK) || (state_reg == lfso_pkg::ST_PIXELS)) && fifo_valid;
  assign fifo_pop  = slot && data_sel;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      lfso_pkg::ST_IDLE: begin
        if (pend_reg) begin
          state_next = lfso_pkg::ST_OVERHEAD;
        end
      end
      lfso_pkg::ST_OVERHEAD: begin
        // black lines come before any window line
        if (ovh_done) begin
          state_next = (black_reg != 8'h00) ? lfso_pkg::ST_BLACK : lfso_pkg::ST_CODE_BEGIN;
        end
      end
      lfso_pkg::ST_BLACK: begin
        if (fifo_valid && last_word && (line_cnt_reg == black_reg - 8'h01)) begin
          state_next = lfso_pkg::ST_CODE_BEGIN;
        end
      end
      lfso_pkg::ST_CODE_BEGIN: begin
        if (any_act) begin
          state_next = lfso_pkg::ST_ID_BEGIN;
        end
      end
      lfso_pkg::ST_ID_BEGIN: begin
        state_next = lfso_pkg::ST_PIXELS;
      end
      lfso_pkg::ST_PIXELS: begin
        if (fifo_valid && last_word) begin
          state_next = lfso_pkg::ST_CODE_END;
        end
      end
      lfso_pkg::ST_CODE_END: begin
        state_next = lfso_pkg::ST_ID_END;
      end
      lfso_pkg::ST_ID_END: begin
        state_next = (row_reg == row_stop) ? lfso_pkg::ST_IDLE : lfso_pkg::ST_CODE_BEGIN;
      end
      default: begin
        state_next = lfso_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= lfso_pkg::ST_IDLE;
    end else if (slot) begin
      state_reg <= state_next;
    end
  end

  // Trigger is held until the sequencer starts; a new trigger wins over the clear
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pend_reg <= 1'b0;
    end else if (frame_trig_in) begin
      pend_reg <= 1'b1;
    end else if (slot && (state_reg == lfso_pkg::ST_IDLE)) begin
      pend_reg <= 1'b0;
    end
  end

  // Counters for overhead, black lines, words and rows
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ovh_cnt_reg  <= 12'h000;
      line_cnt_reg <= 8'h00;
      word_cnt_reg <= 10'h000;
      row_reg      <= 11'h000;
    end else if (slot) begin
      if (state_reg == lfso_pkg::ST_IDLE) begin
        ovh_cnt_reg  <= 12'h000;
        line_cnt_reg <= 8'h00;
        word_cnt_reg <= 10'h000;
      end else if (state_reg == lfso_pkg::ST_OVERHEAD) begin
        ovh_cnt_reg <= ovh_cnt_reg + 12'h001;
        // rows climb from the lower of the two window first rows
        row_reg     <= row_first;
      end else if (data_sel) begin
        word_cnt_reg <= last_word ? 10'h000 : word_cnt_reg + 10'h001;
        if (last_word && (state_reg == lfso_pkg::ST_BLACK)) begin
          line_cnt_reg <= line_cnt_reg + 8'h01;
        end
      end else if ((state_reg == lfso_pkg::ST_ID_END) || ((state_reg == lfso_pkg::ST_CODE_BEGIN) && !any_act)) begin
        row_reg <= row_reg + 11'h001;
      end
    end
  end

  always_comb begin
    sync_pre = cls_trn_reg;
    case (state_reg)
      lfso_pkg::ST_BLACK: begin
        sync_pre = fifo_valid ? cls_blk_reg : cls_trn_reg;
      end
      lfso_pkg::ST_PIXELS: begin
        // class code on plain data slots
        sync_pre = fifo_valid ? cls_img_reg : cls_trn_reg;
      end
      lfso_pkg::ST_CODE_BEGIN: begin
        if (any_act) begin
          sync_pre = {first_row ? `LFSO_TYPE_FS : `LFSO_TYPE_LS, marker_reg};
        end
      end
      lfso_pkg::ST_CODE_END: begin
        sync_pre = {last_row ? `LFSO_TYPE_FE : `LFSO_TYPE_LE, marker_reg};
      end
      lfso_pkg::ST_ID_BEGIN, lfso_pkg::ST_ID_END: begin
        sync_pre = mode8_reg ? {3'b000, hid, 4'h0} : {7'h00, hid};
      end
      default: begin
        sync_pre = cls_trn_reg;
      end
    endcase
  end

  // all lanes change together on the slot
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lane0_out      <= 10'h000;
      lane1_out      <= 10'h000;
      lane2_out      <= 10'h000;
      lane3_out      <= 10'h000;
      sync_word_out  <= 10'h000;
      frame_busy_out <= 1'b0;
    end else if (slot) begin
      lane0_out      <= fmt(data_sel ? fifo_data[9:0] : train_reg, mode8_reg);
      lane1_out      <= fmt(data_sel ? fifo_data[19:10] : train_reg, mode8_reg);
      lane2_out      <= fmt(data_sel ? fifo_data[29:20] : train_reg, mode8_reg);
      lane3_out      <= fmt(data_sel ? fifo_data[39:30] : train_reg, mode8_reg);
      sync_word_out  <= fmt(sync_pre, mode8_reg);
      frame_busy_out <= (state_next != lfso_pkg::ST_IDLE);
    end
  end

  property p_begin_fs;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (slot && (state_reg == lfso_pkg::ST_CODE_BEGIN) && any_act && first_row && !mode8_reg)
      |=> (sync_word_out[9:7] == 3'h5);
  endproperty
  a_begin_fs: assert property (p_begin_fs) else $error("frame start type wrong");
  property p_begin_ls;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (slot && (state_reg == lfso_pkg::ST_CODE_BEGIN) && any_act && !first_row && !mode8_reg)
      |=> (sync_word_out[9:7] == 3'h1);
  endproperty
  a_begin_ls: assert property (p_begin_ls) else $error("line begin type wrong");
  property p_end_fe;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (slot && (state_reg == lfso_pkg::ST_CODE_END) && !mode8_reg)
      |=> (sync_word_out == {($past(last_row) ? 3'h6 : 3'h2), $past(marker_reg)});
  endproperty
  a_end_fe: assert property (p_end_fe) else $error("end code wrong");
  property p_id_follows;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (slot && (state_reg == lfso_pkg::ST_CODE_END)) |=> (state_reg == lfso_pkg::ST_ID_END)[*6];
  endproperty
  a_id_follows: assert property (p_id_follows) else $error("no window id after code");
  property p_id_value;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (slot && (state_reg == lfso_pkg::ST_ID_BEGIN) && !mode8_reg)
      |=> (sync_word_out == {7'h00, $past(win1_act), 2'b00} >> 2) || (sync_word_out == {9'h000, $past(win1_act)});
  endproperty
  a_id_value: assert property (p_id_value) else $error("window id not highest");
  property p_narrow;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (slot && mode8_reg) |=> (sync_word_out[9:8] == 2'b00) && (lane0_out[9:8] == 2'b00);
  endproperty
  a_narrow: assert property (p_narrow) else $error("8-bit word too wide");
  property p_idle_train;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (slot && (state_reg == lfso_pkg::ST_IDLE) && !mode8_reg)
      |=> (lane3_out == $past(train_reg)) && (sync_word_out == $past(cls_trn_reg));
  endproperty
  a_idle_train: assert property (p_idle_train) else $error("idle lanes not training");
  property p_slot_only;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    !slot |=> $stable(sync_word_out) && $stable(lane0_out);
  endproperty
  a_slot_only: assert property (p_slot_only) else $error("lane word changed off slot");
  property p_black_first;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (slot && (state_reg == lfso_pkg::ST_OVERHEAD) && ovh_done && (black_reg != 8'h00))
      |=> (state_reg == lfso_pkg::ST_BLACK);
  endproperty
  a_black_first: assert property (p_black_first) else $error("black lines skipped");
  property p_row_step;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (slot && (state_reg == lfso_pkg::ST_ID_END) && (row_reg != row_stop))
      |=> (row_reg == $past(row_reg) + 11'h001);
  endproperty
  a_row_step: assert property (p_row_step) else $error("row did not advance");
endmodule : lfso_frame_sync_output
`default_nettype wire

// file: verification/lfso_rx_model.sv
// Receiver model: makes the word clock and collects sync codes and window ids.
// Assumes the sync word settles within half a word period after each rise.
`timescale 1ns/100ps
`default_nettype none
module lfso_rx_model (
  // Link side
  input  wire logic [9:0] sync_word_in,
  input  wire logic       mode8_in,
  output logic            word_clk_out
);
  localparam logic [6:0] MARKER = 7'h33;
  logic       aligned = 1'b0;
  logic       grab    = 1'b0;
  logic [9:0] q[$];
  initial word_clk_out = 1'b0;
  always #160 word_clk_out = ~word_clk_out;
  always @(negedge word_clk_out) begin
    if (sync_word_in === (mode8_in ? 10'h0_E9 : 10'h3_A6)) aligned = 1'b1;
    if (aligned && (grab || (mode8_in ? sync_word_in[4:0] === MARKER[6:2] : sync_word_in[6:0] === MARKER))) begin
      q.push_back(sync_word_in);
      grab = !grab;
    end
  end
endmodule : lfso_rx_model
`default_nettype wire

// file: verification/test_lfso_frame_sync_output.sv
// Bench for the frame sync output: registers, two overlapping windows, both word modes.
// Assumes the receiver model in lfso_rx_model.sv.
`timescale 1ns/100ps
`default_nettype none
module test_lfso_frame_sync_output;
  logic        sys_clk_in = 0, rstn_in = 0, word_clk, frame_trig_in = 0, pix_valid_in = 0;
  logic        reg_wr_in = 0, reg_rd_in = 0, mode8 = 0, en = 0, pix_ready_out, frame_busy_out;
  logic [39:0] pix_data_in = 0;
  logic [7:0]  reg_addr_in = 0;
  logic [15:0] reg_wdata_in = 0, reg_rdata_out;
  logic [9:0]  lane0_out, lane1_out, lane2_out, lane3_out, sync_word_out, trn;
  logic [31:0] seed = 32'h6f18_73f0;
  logic [39:0] pq[$];
  logic [39:0] pw;
  int          failures = 0, checks_done = 0;
  localparam logic [7:0]  CA[8] = '{8'h83, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97};
  localparam logic [15:0] CV[8] = '{16'h0033, 16'h0001, 16'h0002, 16'h0000, 16'h0001, 16'h0001, 16'h0002, 16'h0001};
  localparam logic [2:0]  TY[6] = '{3'h5, 3'h2, 3'h5, 3'h2, 3'h1, 3'h6};
  localparam logic [2:0]  WID[6] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h1};
  always #20 sys_clk_in = ~sys_clk_in;
  lfso_frame_sync_output DUT (.sys_clk_in, .rstn_in, .word_clk_in(word_clk), .frame_trig_in, .pix_data_in,
    .pix_valid_in, .pix_ready_out, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .lane0_out, .lane1_out, .lane2_out, .lane3_out, .sync_word_out, .frame_busy_out);
  lfso_rx_model rx (.sync_word_in(sync_word_out), .mode8_in(mode8), .word_clk_out(word_clk));
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xorshift
  function automatic logic [9:0] fm(input logic [9:0] w);
    return mode8 ? {2'b00, w[9:2]} : w;
  endfunction : fm
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    @(posedge sys_clk_in);
    #1 check({24'h00_0000, reg_rdata_out}, {24'h00_0000, exp});
  endtask : rd
  task automatic frame();
    logic [9:0] w;
    rx.q.delete();
    @(posedge sys_clk_in);
    frame_trig_in <= 1'b1;
    @(posedge sys_clk_in);
    frame_trig_in <= 1'b0;
    wait (frame_busy_out === 1'b1);
    wait (frame_busy_out === 1'b0);
    repeat (2) @(negedge word_clk);
    check(rx.q.size(), 12);
    for (int i = 0; i < 6 && rx.q.size() == 12; i++) begin
      w = {TY[i], 7'h33};
      check(rx.q[2*i], mode8 ? {2'b00, w[9:2]} : w);
      check(rx.q[2*i+1], mode8 ? {5'h00, WID[i], 2'b00} : {7'h00, WID[i]});
    end
  endtask : frame
  task automatic summarize();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  assign trn = mode8 ? 10'h0_E9 : 10'h3_A6;
  // Random pixel words keep the queue full
  always @(posedge sys_clk_in) begin
    if (pix_ready_out === 1'b1) begin
      if (pix_valid_in === 1'b1) pq.push_back(pix_data_in);
      pix_data_in <= {8'h00, xorshift()};
    end
  end
  // data slots carry accepted pixel words in order
  always @(negedge word_clk) begin
    if ((sync_word_out === fm(10'h0_15) || sync_word_out === fm(10'h0_35)) && pq.size() > 0) begin
      pw = pq.pop_front();
      check({lane3_out, lane2_out, lane1_out, lane0_out}, {fm(pw[39:30]), fm(pw[29:20]), fm(pw[19:10]), fm(pw[9:0])});
    end
  end
  always @(negedge word_clk) if (en && sync_word_out === trn) check({lane3_out, lane2_out, lane1_out, lane0_out}, {4{trn}});
  initial begin
    #200000;
    failures++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge sys_clk_in);
    rstn_in      <= 1'b1;
    pix_valid_in <= 1'b1;
    rd(8'h83, 16'h002A);
    rd(8'h82, 16'h03A6);
    rd(8'hF0, 16'h0000);
    for (int i = 0; i < 8; i++) wr(CA[i], CV[i]);
    for (int i = 0; i < 8; i++) rd(CA[i], CV[i]);
    for (int m = 0; m < 2; m++) begin
      en = 1'b0;
      wr(8'h90, m[15:0]);
      mode8 = m[0];
      repeat (2) @(negedge word_clk);
      en = 1'b1;
      frame();
    end
    summarize();
  end
endmodule : test_lfso_frame_sync_output
`default_nettype wire
